// ==== write_scheduler.sv ====
// Purpose: Controller end, queues writes and keeps link timing
// Assumes: APB slave on mclk, receiver on the same clock
// Notes: Auto precharge mode serialises writes behind recovery
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/100ps
module wr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic in_vld,
    output logic in_rdy,
    input wire logic [W-1:0] in_data,
    output logic out_vld,
    input wire logic out_rdy,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH: power of two");

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic in_rdy;
        logic out_vld;
    } st_t;

    st_t s;
    st_t n;

    // Push, pop and registered flags
    always_comb begin
        logic push;
        logic pop;
        push = in_vld && s.in_rdy;
        pop = out_rdy && s.out_vld;
        n = s;
        if (push) begin
            n.mem[s.wp] = in_data;
            n.wp = AW'(s.wp + 1'b1);
        end
        if (pop) begin
            n.rp = AW'(s.rp + 1'b1);
        end
        n.cnt = (AW+1)'(s.cnt + push - pop);
        n.in_rdy = (n.cnt != (AW+1)'(DEPTH));
        n.out_vld = (n.cnt != '0);
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s <= '0;
            s.in_rdy <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign in_rdy = s.in_rdy;
    assign out_vld = s.out_vld;
    assign out_data = s.mem[s.rp];
endmodule : wr_fifo

module write_scheduler #(
    parameter int MAX_LAT = 64,
    parameter int INFL = 16,
    parameter int QDEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_vld,
    output logic req_rdy,
    input wire logic req_chop_sel,
    input wire logic [3:0] req_bank,
    input wire logic [9:0] req_col,
    input wire logic [wrburst_pkg::DATA_W-1:0] req_data,
    wrburst_if.ctl lk
);
    localparam int DW = wrburst_pkg::DATA_W;
    localparam int CW = wrburst_pkg::CLK_W;
    localparam int BW = wrburst_pkg::BEAT_W;
    localparam int EW = 15 + DW;
    localparam int IW = $clog2(INFL);
    if (MAX_LAT < 64 || INFL < 16) $error("MAX_LAT/INFL too small");
    if ((1 << IW) != INFL) $error("INFL must be a power of two");

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_PRE = 2'b01
    } phase_t;

    typedef struct packed {
        logic chop;
        logic [3:0] bank;
        logic [9:0] col;
        logic [DW-1:0] data;
    } ent_t;

    typedef struct packed {
        wrburst_pkg::mode_t mode;
        wrburst_pkg::mode_t lm;
        logic auto_pre;
        logic mrs_pend;
        logic [23:0] recov;
        logic [31:0] wtr;
        phase_t ph;
        logic [MAX_LAT-1:0] line;
        ent_t [INFL-1:0] ring;
        logic [IW-1:0] rwp;
        logic [IW-1:0] rrp;
        logic [IW:0] rcnt;
        ent_t cur;
        logic [2:0] cnt;
        logic busy;
        logic [3:0] gap;
        logic [7:0] rec;
        logic [7:0] elap;
        logic [7:0] wcount;
        logic mrs_vld;
        logic wr_vld;
        logic wr_chop_sel;
        logic [3:0] wr_bank;
        logic [9:0] wr_col;
        logic pre_vld;
        logic [3:0] pre_bank;
        logic dq_vld;
        logic [CW-1:0] dq;
        logic [1:0] dbi_n;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } st_t;

    st_t s;
    st_t n;
    logic take;
    logic q_vld;
    ent_t q_ent;

    // ****************************************
    // Request queue
    // ****************************************
    wr_fifo #(.W(EW), .DEPTH(QDEPTH)) u_queue (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_vld(req_vld),
        .in_rdy(req_rdy),
        .in_data({req_chop_sel, req_bank, req_col, req_data}),
        .out_vld(q_vld),
        .out_rdy(take),
        .out_data(q_ent)
    );

    // Register decode, shared by read and write
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == wrburst_pkg::OFS_CTRL)
            || (a == wrburst_pkg::OFS_RECOV)
            || (a == wrburst_pkg::OFS_WTR)
            || (a == wrburst_pkg::OFS_STATUS);
    endfunction : reg_hit

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        ent_t c;
        logic act;
        logic cfg_ok;
        logic busy_all;
        logic idle_link;
        logic last;
        logic inv;
        logic cdm;
        logic [5:0] wl;
        logic [2:0] k;
        logic [2:0] dclk;
        logic [3:0] gap_sel;
        logic [7:0] twr_sel;
        logic [DW-1:0] cd;
        logic [CW-1:0] w;
        logic [BW-1:0] b;
        c = '0;
        act = 1'b0;
        last = 1'b0;
        inv = 1'b0;
        k = 3'h0;
        dclk = 3'h0;
        cd = '0;
        w = '0;
        b = '0;
        take = 1'b0;
        n = s;
        n.mrs_vld = 1'b0;
        n.wr_vld = 1'b0;
        n.pre_vld = 1'b0;
        n.dq_vld = 1'b0;
        n.dq = '0;
        n.dbi_n = 2'h3;
        wl = {1'b0, s.lm.al} + {1'b0, s.lm.write_column_latency};
        cdm = s.lm.crc && s.lm.dm;
        // Two-clock preamble needs latency above the lowest
        cfg_ok = !(s.lm.pre2
            && s.lm.write_column_latency < 5'(wrburst_pkg::CWL_LOWEST + 5'h01));
        // Command spacing; six never used with two-clock preamble
        if (s.lm.crc) begin
            gap_sel = s.lm.pre2 ? wrburst_pkg::GAP_CRC_PRE2
                                : wrburst_pkg::GAP_CRC;
        end else begin
            gap_sel = s.lm.pre2 ? wrburst_pkg::GAP_PLAIN_PRE2
                                : wrburst_pkg::GAP_PLAIN;
        end
        // Recovery variant by inversion and checksum-mask
        if (s.lm.data_bus_inversion) begin
            twr_sel = s.recov[15:8];
        end else if (cdm) begin
            twr_sel = s.recov[23:16];
        end else begin
            twr_sel = s.recov[7:0];
        end
        if (s.gap != 4'h0) begin
            n.gap = 4'(s.gap - 4'h1);
        end
        if (s.rec != 8'h00) begin
            n.rec = 8'(s.rec - 8'h01);
        end
        if (s.elap != 8'hff) begin
            n.elap = 8'(s.elap + 8'h01);
        end
        n.line = {s.line[MAX_LAT-2:0], 1'b0};

        // Data launch, one clock ahead of the link
        if (s.line[6'(wl - 6'h01)]) begin
            c = s.ring[s.rrp];
            act = 1'b1;
            n.rrp = IW'(s.rrp + 1'b1);
        end else begin
            c = s.cur;
            k = s.cnt;
            act = s.busy;
        end
        if (act) begin
            dclk = c.chop ? wrburst_pkg::CLKS_4 : wrburst_pkg::CLKS_8;
            cd = c.data;
            if (c.chop) begin
                cd[DW-1:2*CW] = '0;
            end
            n.dq_vld = 1'b1;
            if (k < dclk) begin
                w = cd[int'(k)*CW +: CW];
                for (int i = 0; i < 2; i++) begin
                    b = w[i*BW +: BW];
                    inv = s.lm.data_bus_inversion && wrburst_pkg::want_invert(b);
                    n.dq[i*BW +: BW] = inv ? ~b : b;
                    n.dbi_n[i] = ~inv;
                end
            end else begin
                n.dq[7:0] = wrburst_pkg::checksum(cd);
            end
            last = (3'(k + 3'h1) == 3'(dclk + {2'b00, s.lm.crc}));
            n.cur = c;
            n.cnt = 3'(k + 3'h1);
            n.busy = !last;
            if (last) begin
                // Recovery and read delay start after the last beat
                n.rec = twr_sel;
                n.elap = 8'h00;
            end
        end

        // ****************************************
        // Command issue
        // ****************************************
        idle_link = (s.rcnt == '0) && !s.busy && (s.line == '0);
        case (s.ph)
            PH_IDLE: begin
                if (s.mrs_pend && idle_link && s.gap == 4'h0) begin
                    n.mrs_vld = 1'b1;
                    n.lm = s.mode;
                    n.mrs_pend = 1'b0;
                end else if (!s.mrs_pend && q_vld && cfg_ok
                    && s.gap == 4'h0
                    && s.rcnt != (IW+1)'(INFL)) begin
                    take = 1'b1;
                    c = q_ent;
                    c.chop = wrburst_pkg::is_chop(s.lm.bm, q_ent.chop);
                    n.ring[s.rwp] = c;
                    n.rwp = IW'(s.rwp + 1'b1);
                    n.line[0] = 1'b1;
                    n.wr_vld = 1'b1;
                    n.wr_chop_sel = q_ent.chop;
                    n.wr_bank = q_ent.bank;
                    n.wr_col = q_ent.col;
                    n.gap = 4'(gap_sel - 4'h1);
                    n.wcount = 8'(s.wcount + 8'h01);
                    n.ph = s.auto_pre ? PH_PRE : PH_IDLE;
                end
            end
            PH_PRE: begin
                // Latency, burst tail and recovery all elapsed
                if (idle_link && s.rec == 8'h00 && !s.dq_vld) begin
                    n.pre_vld = 1'b1;
                    n.pre_bank = s.wr_bank;
                    n.ph = PH_IDLE;
                end
            end
            default: begin
                n.ph = PH_IDLE;
            end
        endcase
        n.rcnt = (IW+1)'(s.rcnt + take - act);
        if (s.line[6'(wl - 6'h01)] == 1'b0) begin
            n.rcnt = (IW+1)'(s.rcnt + take);
        end

        // ****************************************
        // APB slave, answer one cycle into access
        // ****************************************
        busy_all = !idle_link || q_vld || s.ph == PH_PRE;
        n.pready = psel && penable && !s.pready;
        n.pslverr = n.pready && !reg_hit(paddr);
        if (n.pready) begin
            case (paddr)
                wrburst_pkg::OFS_CTRL:
                    n.prdata = {15'h0000, s.auto_pre, s.mode};
                wrburst_pkg::OFS_RECOV: n.prdata = {8'h00, s.recov};
                wrburst_pkg::OFS_WTR: n.prdata = s.wtr;
                wrburst_pkg::OFS_STATUS: n.prdata = {16'h0000,
                    s.wcount, 3'h0, s.mrs_pend,
                    !s.busy && s.elap >= (cdm ? s.wtr[31:24]
                                              : s.wtr[15:8]),
                    !s.busy && s.elap >= (cdm ? s.wtr[23:16]
                                              : s.wtr[7:0]),
                    !cfg_ok, busy_all};
                default: n.prdata = 32'h00000000;
            endcase
        end
        // Writes land on the completing edge; set beats the clear
        if (psel && penable && s.pready && pwrite) begin
            case (paddr)
                wrburst_pkg::OFS_CTRL: begin
                    n.mode = pwdata[15:0];
                    n.auto_pre = pwdata[wrburst_pkg::CTRL_AUTO_PRE];
                    n.mrs_pend = 1'b1;
                end
                wrburst_pkg::OFS_RECOV: n.recov = pwdata[23:0];
                wrburst_pkg::OFS_WTR: n.wtr = pwdata;
                default: n.wtr = n.wtr;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s <= '0;
            s.mode <= wrburst_pkg::MODE_RST;
            s.lm <= wrburst_pkg::MODE_RST;
            s.recov <= wrburst_pkg::RECOV_RST;
            s.wtr <= wrburst_pkg::WTR_RST;
            s.dbi_n <= 2'h3;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign lk.mrs_vld = s.mrs_vld;
    assign lk.mrs_mode = s.lm;
    assign lk.wr_vld = s.wr_vld;
    assign lk.wr_chop_sel = s.wr_chop_sel;
    assign lk.wr_bank = s.wr_bank;
    assign lk.wr_col = s.wr_col;
    assign lk.pre_vld = s.pre_vld;
    assign lk.pre_bank = s.pre_bank;
    assign lk.dq_vld = s.dq_vld;
    assign lk.dq = s.dq;
    assign lk.dbi_n = s.dbi_n;
endmodule : write_scheduler

// ==== wrburst_pkg.sv ====
// Purpose: Shared constants, types and helpers for the write link
// Assumes: One clock, two data beats carried on each clock
// Notes: Used by the scheduler, the receiver and the link interface
package wrburst_pkg;
    // ****************************************
    // Widths and burst shapes
    // ****************************************
    localparam int BEAT_W = 16;
    localparam int CLK_W = 2 * BEAT_W;
    localparam int DATA_W = 4 * CLK_W;
    localparam logic [1:0] BM_FIXED8 = 2'h0;
    localparam logic [1:0] BM_OTF = 2'h1;
    localparam logic [1:0] BM_FIXED4 = 2'h2;
    localparam logic [2:0] CLKS_8 = 3'h4;
    localparam logic [2:0] CLKS_4 = 3'h2;
    localparam logic [3:0] GAP_PLAIN = 4'h4;
    localparam logic [3:0] GAP_PLAIN_PRE2 = 4'h5;
    localparam logic [3:0] GAP_CRC = 4'h5;
    localparam logic [3:0] GAP_CRC_PRE2 = 4'h7;
    localparam logic [4:0] CWL_LOWEST = 5'h09;

    // ****************************************
    // Register map of the scheduler
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RECOV = 8'h04;
    localparam logic [7:0] OFS_WTR = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam int CTRL_AUTO_PRE = 16;
    localparam logic [15:0] MODE_RST = 16'h0240;
    localparam logic [23:0] RECOV_RST = 24'h0c0c0c;
    localparam logic [31:0] WTR_RST = 32'h06020602;

    // Mode word carried by the mode-set command
    typedef struct packed {
        logic [4:0] al;
        logic [4:0] write_column_latency;
        logic pre2;
        logic dm;
        logic crc;
        logic data_bus_inversion;
        logic [1:0] bm;
    } mode_t;

    // One write command as seen by the receiver
    typedef struct packed {
        logic vld;
        logic chop;
        logic crc;
        logic [3:0] bank;
        logic [9:0] col;
    } wcmd_t;

    // Chop decision from burst field and chop bit
    function automatic logic is_chop(input logic [1:0] bm,
                                     input logic sel);
        case (bm)
            BM_FIXED8: is_chop = 1'b0;
            BM_OTF: is_chop = ~sel;
            BM_FIXED4: is_chop = 1'b1;
            default: is_chop = 1'b0;
        endcase
    endfunction : is_chop

    // Byte checksum over a whole burst
    function automatic logic [7:0] checksum(input logic [DATA_W-1:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < DATA_W / 8; i++) begin
            c = {c[6:0], c[7]} ^ d[i*8 +: 8];
        end
        checksum = c;
    endfunction : checksum

    // Invert a beat when zeros are the majority
    function automatic logic want_invert(input logic [BEAT_W-1:0] b);
        int z;
        z = 0;
        for (int i = 0; i < BEAT_W; i++) begin
            z = z + int'(~b[i]);
        end
        want_invert = (z > BEAT_W / 2);
    endfunction : want_invert
endpackage : wrburst_pkg

// ==== wrburst_if.sv ====
// Purpose: Link between write scheduler and memory receiver
// Assumes: Both ends on mclk, all signals driven from flip-flops
// Notes: Scheduler drives everything, receiver only listens
`timescale 1ns/100ps
interface wrburst_if (
    input wire logic mclk,
    input wire logic rst_b
);
    logic mrs_vld;
    wrburst_pkg::mode_t mrs_mode;
    logic wr_vld;
    logic wr_chop_sel;
    logic [3:0] wr_bank;
    logic [9:0] wr_col;
    logic pre_vld;
    logic [3:0] pre_bank;
    logic dq_vld;
    logic [wrburst_pkg::CLK_W-1:0] dq;
    logic [1:0] dbi_n;

    modport ctl (input mclk, rst_b, output mrs_vld, mrs_mode, wr_vld,
                 wr_chop_sel, wr_bank, wr_col, pre_vld, pre_bank,
                 dq_vld, dq, dbi_n);
    modport mem (input mclk, rst_b, mrs_vld, mrs_mode, wr_vld,
                 wr_chop_sel, wr_bank, wr_col, pre_vld, pre_bank,
                 dq_vld, dq, dbi_n);
endinterface : wrburst_if

// ==== burst_receiver.sv ====
// Purpose: Memory end, collects write bursts after write latency
// Assumes: Scheduler keeps spacing and latency limits
// Notes: Delay line lets several writes be in flight at once
`timescale 1ns/100ps
module burst_receiver #(
    parameter int MAX_LAT = 64
) (
    wrburst_if.mem lk,
    output logic rx_vld,
    output logic rx_chop,
    output logic [3:0] rx_bank,
    output logic [9:0] rx_col,
    output logic [wrburst_pkg::DATA_W-1:0] rx_data,
    output logic rx_crc_err,
    output logic pre_seen,
    output logic [3:0] pre_seen_bank,
    output logic [1:0] burst_mode
);
    if (MAX_LAT < 64) $error("MAX_LAT must cover al plus cwl");

    typedef struct packed {
        wrburst_pkg::mode_t mode;
        wrburst_pkg::wcmd_t [MAX_LAT-1:0] line;
        wrburst_pkg::wcmd_t cur;
        logic [2:0] cnt;
        logic busy;
        logic [wrburst_pkg::DATA_W-1:0] acc;
        logic rx_vld;
        logic rx_crc_err;
        logic pre_seen;
        logic [3:0] pre_bank;
    } st_t;

    st_t s;
    st_t n;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        wrburst_pkg::wcmd_t rec;
        wrburst_pkg::wcmd_t tap;
        wrburst_pkg::wcmd_t c;
        logic [5:0] wl;
        logic [2:0] k;
        logic [2:0] dclk;
        logic [wrburst_pkg::BEAT_W-1:0] b;
        logic [wrburst_pkg::CLK_W-1:0] w;
        logic act;
        rec = '0;
        tap = '0;
        c = '0;
        k = 3'h0;
        dclk = 3'h0;
        b = '0;
        w = '0;
        act = 1'b0;
        n = s;
        n.rx_vld = 1'b0;
        n.pre_seen = 1'b0;
        wl = {1'b0, s.mode.al} + {1'b0, s.mode.write_column_latency};
        if (lk.mrs_vld) begin
            n.mode = lk.mrs_mode;
        end
        // Capture the burst shape with each command
        if (lk.wr_vld) begin
            rec.vld = 1'b1;
            rec.chop = wrburst_pkg::is_chop(s.mode.bm, lk.wr_chop_sel);
            rec.crc = s.mode.crc;
            rec.bank = lk.wr_bank;
            rec.col = lk.wr_col;
        end
        // Shift every clock, so any spacing is taken
        n.line = {s.line[MAX_LAT-2:0], rec};
        tap = s.line[6'(wl - 6'h01)];
        // Undo data inversion beat by beat
        for (int i = 0; i < 2; i++) begin
            b = lk.dq[i*wrburst_pkg::BEAT_W +: wrburst_pkg::BEAT_W];
            if (s.mode.data_bus_inversion && !lk.dbi_n[i]) begin
                b = ~b;
            end
            w[i*wrburst_pkg::BEAT_W +: wrburst_pkg::BEAT_W] = b;
        end
        if (tap.vld) begin
            c = tap;
            act = 1'b1;
            n.acc = '0;
        end else begin
            c = s.cur;
            k = s.cnt;
            act = s.busy;
        end
        if (act) begin
            dclk = c.chop ? wrburst_pkg::CLKS_4 : wrburst_pkg::CLKS_8;
            if (k < dclk) begin
                n.acc[int'(k)*wrburst_pkg::CLK_W +: wrburst_pkg::CLK_W] = w;
            end
            n.cur = c;
            n.cnt = 3'(k + 3'h1);
            n.busy = (3'(k + 3'h1) != 3'(dclk + {2'b00, c.crc}));
            if (!n.busy) begin
                n.rx_vld = 1'b1;
                n.rx_crc_err = c.crc
                    && (w[7:0] != wrburst_pkg::checksum(n.acc));
            end
        end
        if (lk.pre_vld) begin
            n.pre_seen = 1'b1;
            n.pre_bank = lk.pre_bank;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge lk.mclk) begin
        if (!lk.rst_b) begin
            s <= '0;
            s.mode <= wrburst_pkg::MODE_RST;
        end else begin
            s <= n;
        end
    end

    assign rx_vld = s.rx_vld;
    assign rx_chop = s.cur.chop;
    assign rx_bank = s.cur.bank;
    assign rx_col = s.cur.col;
    assign rx_data = s.acc;
    assign rx_crc_err = s.rx_crc_err;
    assign pre_seen = s.pre_seen;
    assign pre_seen_bank = s.pre_bank;
    assign burst_mode = s.mode.bm;
endmodule : burst_receiver

// ==== wrburst_properties.sv ====
// Purpose: Link timing checks
// Assumes: Burst length checks only with cwl 9, al 0
// Notes: Link signals only
`timescale 1ns/100ps
module wrburst_properties (
    input wire logic mclk,
    input wire logic rst_b,
    input wrburst_pkg::mode_t mrs_mode,
    input wire logic wr_vld,
    input wire logic wr_chop_sel,
    input wire logic pre_vld,
    input wire logic dq_vld,
    input wire logic [1:0] dbi_n
);
    // ****************
    // Link properties
    // ****************
    logic [7:0] since_ff, nxt_since;
    logic lat9;
    logic [1:0] bm;
    // Mode decode and write age
    assign lat9 = mrs_mode.al == 5'h00 && mrs_mode.write_column_latency == 5'h09;
    assign bm = mrs_mode.bm;
    assign nxt_since = wr_vld ? 8'h01 : since_ff + {7'h0, ~&since_ff};
    // Saturating age counter
    always_ff @(posedge mclk) begin
        since_ff <= rst_b ? nxt_since : 8'hff;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    gap_plain_a: assert property (wr_vld |=> !wr_vld [*3])
        else $error("write gap below 4");
    gap_crc_a: assert property (wr_vld && mrs_mode.crc |=> !wr_vld [*4])
        else $error("crc gap below 5");
    gap_pre2_a: assert property (wr_vld && mrs_mode.crc && mrs_mode.pre2
        |=> !wr_vld [*6]) else $error("pre2 gap below 7");
    cwl_floor_a: assert property (wr_vld |-> !(mrs_mode.pre2 &&
        mrs_mode.write_column_latency <= wrburst_pkg::CWL_LOWEST))
        else $error("latency too low");
    fixed_eight_a: assert property (wr_vld && lat9 && bm == 2'h0
        |-> ##9 dq_vld [*4]) else $error("fixed burst short");
    sel_eight_a: assert property (wr_vld && lat9 && bm == 2'h1
        && wr_chop_sel |-> ##9 dq_vld [*4]) else $error("burst short");
    sel_chop_a: assert property (wr_vld && lat9 && !mrs_mode.crc
        && bm == 2'h1 && !wr_chop_sel |-> ##9 dq_vld [*2] ##1 !dq_vld)
        else $error("chop long");
    fixed_chop_a: assert property (wr_vld && lat9 && !mrs_mode.crc
        && bm == 2'h2 |-> ##9 dq_vld [*2] ##1 !dq_vld)
        else $error("fixed chop long");
    inv_idle_a: assert property ((!dq_vld || !mrs_mode.data_bus_inversion)
        |-> dbi_n == 2'h3) else $error("stray inversion");
    pre_space_a: assert property (pre_vld |-> int'(since_ff) >=
        int'(mrs_mode.al) + int'(mrs_mode.write_column_latency) + (bm == 2'h2 ? 14 : 16))
        else $error("precharge too soon");
endmodule : wrburst_properties

// ==== sdram_write_burst_options_test.sv ====
// Purpose: Bench for both link ends
// Assumes: Default recovery values
// Notes: Rows, then refusal, queue, reset
`timescale 1ns/100ps
module sdram_write_burst_options_test;
    // ****************
    // Bench
    // ****************
    typedef struct packed {
        logic [16:0] ctrl;
        logic sel;
        logic chop;
    } row_t;
    row_t rows [8] = '{'{17'h00240, 1'b0, 1'b0}, '{17'h00241, 1'b0, 1'b1},
        '{17'h00241, 1'b1, 1'b0}, '{17'h00242, 1'b1, 1'b1},
        '{17'h00245, 1'b0, 1'b1}, '{17'h00258, 1'b0, 1'b0},
        '{17'h002a9, 1'b1, 1'b0}, '{17'h10248, 1'b0, 1'b0}};
    logic [31:0] rv [3] = '{32'h00000240, 32'h000c0c0c, 32'h06020602};
    logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, req_vld = 1'b0, req_chop_sel = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err_b, req_rdy, rx_vld, rx_chop, rx_crc_err;
    logic pre_seen;
    logic [3:0] req_bank = 4'h0, pre_seen_bank;
    logic [1:0] burst_mode;
    logic [wrburst_pkg::DATA_W-1:0] req_data = '0, rx_data, d;
    int error_cnt = 0, n_checks = 0, rx_cnt = 0, pre_cnt = 0, t0;
    always #10 mclk = ~mclk;
    wrburst_if wrburst_if_inst (.mclk, .rst_b);
    write_scheduler write_scheduler_inst (.mclk, .rst_b, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .req_vld,
        .req_rdy, .req_chop_sel, .req_bank, .req_col(10'h000), .req_data,
        .lk(wrburst_if_inst));
    burst_receiver burst_receiver_inst (.lk(wrburst_if_inst), .rx_vld,
        .rx_chop, .rx_bank(), .rx_col(), .rx_data, .rx_crc_err, .pre_seen,
        .pre_seen_bank, .burst_mode);
    wrburst_properties wrburst_properties_inst (.mclk, .rst_b,
        .mrs_mode(wrburst_if_inst.mrs_mode),
        .wr_vld(wrburst_if_inst.wr_vld), .pre_vld(wrburst_if_inst.pre_vld),
        .wr_chop_sel(wrburst_if_inst.wr_chop_sel),
        .dq_vld(wrburst_if_inst.dq_vld), .dbi_n(wrburst_if_inst.dbi_n));
    // Count receiver pulses
    always @(posedge mclk) begin
        rx_cnt <= rx_cnt + int'(rx_vld === 1'b1);
        pre_cnt <= pre_cnt + int'(pre_seen === 1'b1);
    end
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    task automatic chk_w(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk_w
    task automatic chk_d(input logic [wrburst_pkg::DATA_W-1:0] e, g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected rx_data exp %h got %h", e, g);
        end
    endtask : chk_d
    task automatic limit(input bit hit);
        if (hit) begin
            error_cnt++;
            close_out();
        end
    endtask : limit
    // Bounded wait on a counter
    task automatic wait_on(ref int c, input int t);
        for (int n = 0; n < 900 && c < t; n++) begin
            @(posedge mclk);
        end
        limit(c < t);
    endtask : wait_on
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] w);
        int n = 0;
        @(posedge mclk);
        paddr <= a;
        pwrite <= wr;
        pwdata <= w;
        psel <= 1'b1;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err_b = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        limit(pready !== 1'b1);
    endtask : apb
    task automatic req(input logic s, input logic [3:0] b,
                       input logic [wrburst_pkg::DATA_W-1:0] v);
        int n = 0;
        @(posedge mclk);
        req_vld <= 1'b1;
        req_chop_sel <= s;
        req_bank <= b;
        req_data <= v;
        do begin
            @(posedge mclk);
            n++;
        end while (req_rdy !== 1'b1 && n < 900);
        req_vld <= 1'b0;
        limit(req_rdy !== 1'b1);
    endtask : req
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, wrburst_pkg::OFS_CTRL, {15'h0, rows[i].ctrl});
            d = {4{32'hfff00001}} + 128'(i);
            req(rows[i].sel, 4'(i), d);
            wait_on(rx_cnt, i + 1);
            chk_w("rx_chop", {31'h0, rows[i].chop}, {31'h0, rx_chop});
            chk_d(rows[i].chop ? {64'h0, d[63:0]} : d, rx_data);
            chk_w("rx_crc_err", 32'h0, {31'h0, rx_crc_err});
            chk_w("mode", {30'h0, rows[i].ctrl[1:0]}, {30'h0, burst_mode});
            $display("row %0d done", i);
        end
        wait_on(pre_cnt, 1);
        chk_w("pre_bank", 32'h7, {28'h0, pre_seen_bank});
        apb(1'b0, 8'h10, 32'h0);
        chk_w("pslverr", 32'h1, {31'h0, err_b});
        $display("unmapped test done");
        apb(1'b1, wrburst_pkg::OFS_CTRL, 32'h00000260);
        t0 = rx_cnt;
        for (int k = 0; k < 8; k++) begin
            req(1'b1, 4'(k), d);
        end
        repeat (3) @(posedge mclk);
        chk_w("req_rdy", 32'h0, {31'h0, req_rdy});
        apb(1'b0, wrburst_pkg::OFS_STATUS, 32'h0);
        chk_w("cfg_err", 32'h1, {31'h0, rd[1]});
        apb(1'b1, wrburst_pkg::OFS_CTRL, 32'h00000248);
        wait_on(rx_cnt, t0 + 8);
        $display("queue test done");
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            chk_w("reset value", rv[k], rd);
        end
        $display("reset test done");
        close_out();
    end
endmodule : sdram_write_burst_options_test
